// ---- pkg/sfb_pkg.sv ----
/*
 * sfb_pkg: shared constants, enumerations and carrier structs for the
 * serial flash bus front end.
 * assumes: a single system clock domain that oversamples the serial pins.
 */
package sfb_pkg;

	// ========================================================================
	// pin sampling
	// ========================================================================
	localparam int SFB_SYNC_DEPTH = 3;       // flops in each pin synchroniser
	localparam int SFB_BYTE_BITS = 8;
	localparam int SFB_ADDR_BYTES = 3;
	localparam int SFB_PAGE_BYTES = 256;     // most data bytes one program takes
	localparam int SFB_SEC_PAGES = 3;        // separate security pages

	// ========================================================================
	// pin reset levels (select idles high, clock and data idle low)
	// ========================================================================
	localparam logic SFB_SELECT_IDLE = 1'b1;
	localparam logic SFB_SCK_IDLE = 1'b0;
	localparam logic SFB_LANE_IDLE = 1'b0;

	// ========================================================================
	// command codes and header layout
	// ========================================================================
	localparam logic [7:0] SFB_OPC_READ = 8'h03;
	localparam logic [7:0] SFB_OPC_FAST_READ = 8'h0b;
	localparam logic [7:0] SFB_OPC_DUAL_READ = 8'h3b;
	localparam logic [7:0] SFB_OPC_QUAD_READ = 8'h6b;
	localparam logic [7:0] SFB_OPC_PROGRAM = 8'h02;
	localparam logic [7:0] SFB_OPC_ERASE_4K = 8'h20;
	localparam logic [7:0] SFB_OPC_ERASE_32K = 8'h52;
	localparam logic [7:0] SFB_OPC_ERASE_64K = 8'hd8;
	localparam logic [7:0] SFB_OPC_ERASE_CHIP = 8'h60;
	localparam logic [7:0] SFB_OPC_SEC_ERASE = 8'h44;
	localparam logic [7:0] SFB_OPC_SEC_PROGRAM = 8'h42;
	localparam logic [7:0] SFB_OPC_SEC_READ = 8'h48;
	localparam logic [2:0] SFB_DUMMY_BYTES = 3'h1; // wait byte of the fast reads
	localparam int SFB_SEC_PAGE_LSB = 12;    // address bits naming a security page

	// ========================================================================
	// types
	// ========================================================================
	typedef enum logic [1:0] {
		SFB_LANES_1 = 2'h0,
		SFB_LANES_2 = 2'h1,
		SFB_LANES_4 = 2'h2
	} sfb_lanes_t;

	typedef enum logic [2:0] {
		SFB_OP_NONE = 3'h0,
		SFB_OP_PROGRAM = 3'h1,
		SFB_OP_ERASE_4K = 3'h2,
		SFB_OP_ERASE_32K = 3'h3,
		SFB_OP_ERASE_64K = 3'h4,
		SFB_OP_ERASE_CHIP = 3'h5,
		SFB_OP_SEC_PROGRAM = 3'h6,
		SFB_OP_SEC_ERASE = 3'h7
	} sfb_op_kind_t;

	// one received byte
	typedef struct packed {
		logic valid;
		logic is_cmd;
		logic is_data;
		logic [7:0] index;
		logic [7:0] data;
	} sfb_rx_t;

	// one operation handed on when the frame closes
	typedef struct packed {
		logic valid;
		sfb_op_kind_t kind;
		logic [23:0] addr;
		logic [8:0] count;
		logic [1:0] page;
	} sfb_op_t;

endpackage

// ---- rtl/sfb_pin_sync.sv ----
/*
 * sfb_pin_sync: three-flop synchroniser and edge finder for a group of pins.
 * assumes: pins are asynchronous to clock_in and change slower than
 * two clock periods.
 */
`timescale 1ns/100ps

module sfb_pin_sync #(
	parameter int WIDTH = 3,
	parameter logic [WIDTH-1:0] IDLE = '0
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] pins_in,
	output logic [WIDTH-1:0] level_out,
	output logic [WIDTH-1:0] rise_out,
	output logic [WIDTH-1:0] fall_out
);

	// ========================================================================
	// per pin chain
	// ========================================================================
	for (genvar i = 0; i < WIDTH; i++) begin : g_pin
		logic s1_q;
		logic s2_q;
		logic s3_q;
		logic lvl_q;
		logic rise_q;
		logic fall_q;

		// first flop is read only by the second
		always_ff @(posedge clock_in) begin
			if (!rst_n_in) begin
				s1_q <= IDLE[i];
				s2_q <= IDLE[i];
				s3_q <= IDLE[i];
			end else begin
				s1_q <= pins_in[i];
				s2_q <= s1_q;
				s3_q <= s2_q;
			end
		end

		// a change counts once the second and third flops agree
		always_ff @(posedge clock_in) begin
			if (!rst_n_in) begin
				lvl_q <= IDLE[i];
				rise_q <= 1'b0;
				fall_q <= 1'b0;
			end else begin
				rise_q <= (s2_q == s3_q) && s3_q && !lvl_q;
				fall_q <= (s2_q == s3_q) && !s3_q && lvl_q;
				if (s2_q == s3_q) begin
					lvl_q <= s3_q;
				end
			end
		end

		assign level_out[i] = lvl_q;
		assign rise_out[i] = rise_q;
		assign fall_out[i] = fall_q;
	end

endmodule

// ---- rtl/sfb_serial_front.sv ----
/*
 * sfb_serial_front: serial bus front end of a small serial flash.
 * Frames operations by the active-low select, shifts command, address and
 * write data in on lane 0, shifts read data out on one, two or four lanes,
 * and hands finished program / erase operations to the array controller.
 * assumes: the serial clock is far slower than clock_in (at least eight
 * clock_in periods per half cycle); the array controller reports busy_in
 * while a self-timed cycle runs and supplies read bytes on tx_data_in.
 */
`timescale 1ns/100ps

// What this block does
// - The device answers only while the active-low select is held low.
// - Releasing select deselects the device into standby, never deep power-down.
// - While deselected the serial output lane is released to high impedance.
// - While deselected nothing on the serial input lane is accepted.
// - Every operation starts only at a falling edge of select.
// - A rising edge of select ends the operation.
// - Ending a self-timed program or erase keeps the device active until it completes.
// - Command, address and write data bits are taken on rising serial clock edges.
// - Output bits change only on falling serial clock edges, one per edge in single mode.
// - Dual and quad reads turn lane 0 into an output, two or four bits per falling edge.
// - Serial clock modes 0 and 3 both work, whichever level the clock idles at.
// - A program needs at least 1 data byte; its count holds at PAGE_BYTES (256 by default) when more are sent.
// - Erases come at 4, 32 and 64 Kbyte blocks and for the whole array.
// - Three security pages exist and each one locks on its own.
// - Quad reads also drive lanes 2 and 3 in place of the protect and hold inputs.
module sfb_serial_front #(
	parameter int PAGE_BYTES = sfb_pkg::SFB_PAGE_BYTES
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic select_n_in,
	input wire logic sck_in,
	input wire logic [3:0] shared_lane_in,
	output logic [3:0] shared_lane_out,
	output logic [3:0] shared_lane_oe_out,
	input wire logic busy_in,
	input wire logic [2:0] sec_lock_in,
	input wire logic [7:0] tx_data_in,
	output logic tx_req_out,
	output sfb_pkg::sfb_rx_t rx_out,
	output sfb_pkg::sfb_op_t op_out,
	output logic selected_out,
	output logic standby_out,
	output logic frame_start_out,
	output logic frame_end_out
);

	// ========================================================================
	// elaboration check
	// ========================================================================
	if (PAGE_BYTES < 1 || PAGE_BYTES > sfb_pkg::SFB_PAGE_BYTES) begin : g_bad_page
		$error("PAGE_BYTES must lie between 1 and 256");
	end

	localparam logic [8:0] PAGE_MAX = 9'(PAGE_BYTES);

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CMD = 3'b001,
		ST_ADDR = 3'b011,
		ST_DATA_IN = 3'b010,
		ST_DATA_OUT = 3'b111
	} sfb_state_t;

	// ========================================================================
	// pin synchronisers: select, clock, lane 0
	// ========================================================================
	logic [2:0] pin_lvl;
	logic [2:0] pin_rise;
	logic [2:0] pin_fall;

	sfb_pin_sync #(
		.WIDTH(3),
		.IDLE({sfb_pkg::SFB_LANE_IDLE, sfb_pkg::SFB_SCK_IDLE, sfb_pkg::SFB_SELECT_IDLE})
	) u_sync (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.pins_in({shared_lane_in[0], sck_in, select_n_in}),
		.level_out(pin_lvl),
		.rise_out(pin_rise),
		.fall_out(pin_fall)
	);

	logic sel_active;
	logic sel_start;
	logic sel_end;
	logic sck_rise;
	logic sck_fall;
	logic si_bit;

	assign sel_active = !pin_lvl[0];
	assign sel_start = pin_fall[0];
	assign sel_end = pin_rise[0];
	// clock edges only count while selected; idle level is irrelevant
	assign sck_rise = pin_rise[1] && sel_active && !sel_start;
	assign sck_fall = pin_fall[1] && sel_active && !sel_start;
	assign si_bit = pin_lvl[2];

	// ========================================================================
	// state
	// ========================================================================
	sfb_state_t state_q;
	sfb_state_t state_d;
	logic [2:0] bit_cnt_q;
	logic [7:0] rx_shift_q;
	logic [7:0] opcode_q;
	logic [2:0] hdr_cnt_q;
	logic [2:0] hdr_len_q;
	logic [23:0] addr_q;
	logic [8:0] data_cnt_q;
	logic [7:0] data_idx_q;
	sfb_pkg::sfb_lanes_t lanes_q;
	logic [2:0] out_cnt_q;
	logic [7:0] tx_shift_q;
	logic [3:0] lane_out_q;
	logic [3:0] lane_oe_q;
	logic standby_q;
	sfb_pkg::sfb_rx_t rx_q;
	sfb_pkg::sfb_op_t op_q;

	logic byte_done;
	logic [7:0] byte_val;

	// bit taken on rise from lane 0, msb first
	assign byte_val = {rx_shift_q[6:0], si_bit};
	assign byte_done = sck_rise && (bit_cnt_q == 3'h7) && (state_q != ST_DATA_OUT);

	// ========================================================================
	// input shifter and bit counter
	// ========================================================================
	// input sampling
	always_ff @(posedge clock_in) begin
		if (!rst_n_in || sel_start) begin
			bit_cnt_q <= 3'h0;
			rx_shift_q <= 8'h00;
		end else if (sck_rise && state_q != ST_DATA_OUT && state_q != ST_IDLE) begin
			bit_cnt_q <= bit_cnt_q + 3'h1;
			rx_shift_q <= byte_val;
		end
	end

	// ========================================================================
	// frame state machine
	// ========================================================================
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (sel_start) begin
					state_d = ST_CMD;
				end
			end
			ST_CMD: begin
				if (byte_done) begin
					unique case (byte_val)
						sfb_pkg::SFB_OPC_READ, sfb_pkg::SFB_OPC_FAST_READ,
						sfb_pkg::SFB_OPC_DUAL_READ, sfb_pkg::SFB_OPC_QUAD_READ,
						sfb_pkg::SFB_OPC_PROGRAM, sfb_pkg::SFB_OPC_ERASE_4K,
						sfb_pkg::SFB_OPC_ERASE_32K, sfb_pkg::SFB_OPC_ERASE_64K,
						sfb_pkg::SFB_OPC_SEC_ERASE, sfb_pkg::SFB_OPC_SEC_PROGRAM,
						sfb_pkg::SFB_OPC_SEC_READ: begin
							state_d = ST_ADDR;
						end
						default: begin
							state_d = ST_DATA_IN;
						end
					endcase
				end
			end
			ST_ADDR: begin
				if (byte_done && hdr_cnt_q == hdr_len_q - 3'h1) begin
					state_d = is_read(opcode_q) ? ST_DATA_OUT : ST_DATA_IN;
				end
			end
			ST_DATA_IN, ST_DATA_OUT: begin
				state_d = state_q;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		if (sel_end || !sel_active) begin
			state_d = ST_IDLE;
		end
		if (sel_start) begin
			state_d = ST_CMD;
		end
	end

	function automatic logic is_read(input logic [7:0] opc);
		is_read = (opc == sfb_pkg::SFB_OPC_READ) || (opc == sfb_pkg::SFB_OPC_FAST_READ)
			|| (opc == sfb_pkg::SFB_OPC_DUAL_READ) || (opc == sfb_pkg::SFB_OPC_QUAD_READ)
			|| (opc == sfb_pkg::SFB_OPC_SEC_READ);
	endfunction

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ========================================================================
	// header capture: opcode, address, wait bytes, lane mode
	// ========================================================================
	always_ff @(posedge clock_in) begin
		if (!rst_n_in || sel_start) begin
			opcode_q <= 8'h00;
			hdr_cnt_q <= 3'h0;
			hdr_len_q <= 3'(sfb_pkg::SFB_ADDR_BYTES);
			addr_q <= 24'h000000;
			lanes_q <= sfb_pkg::SFB_LANES_1;
		end else if (byte_done && state_q == ST_CMD) begin
			opcode_q <= byte_val;
			// fast reads carry one wait byte after the address
			if (is_read(byte_val) && byte_val != sfb_pkg::SFB_OPC_READ) begin
				hdr_len_q <= 3'(sfb_pkg::SFB_ADDR_BYTES) + sfb_pkg::SFB_DUMMY_BYTES;
			end
			// lane count chosen by the read command
			if (byte_val == sfb_pkg::SFB_OPC_DUAL_READ) begin
				lanes_q <= sfb_pkg::SFB_LANES_2;
			end else if (byte_val == sfb_pkg::SFB_OPC_QUAD_READ) begin
				lanes_q <= sfb_pkg::SFB_LANES_4;
			end
		end else if (byte_done && state_q == ST_ADDR) begin
			hdr_cnt_q <= hdr_cnt_q + 3'h1;
			// address bytes arrive high byte first
			if (hdr_cnt_q < 3'(sfb_pkg::SFB_ADDR_BYTES)) begin
				addr_q <= {addr_q[15:0], byte_val};
			end
		end
	end

	// ========================================================================
	// write data counting
	// ========================================================================
	// count saturates at a page; the 8-bit index wraps at 256
	always_ff @(posedge clock_in) begin
		if (!rst_n_in || sel_start) begin
			data_cnt_q <= 9'h000;
			data_idx_q <= 8'h00;
		end else if (byte_done && state_q == ST_DATA_IN) begin
			data_idx_q <= data_idx_q + 8'h01;
			if (data_cnt_q != PAGE_MAX) begin
				data_cnt_q <= data_cnt_q + 9'h001;
			end
		end
	end

	// ========================================================================
	// received byte stream to the array controller
	// ========================================================================
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			rx_q <= '0;
		end else begin
			rx_q.valid <= byte_done && state_q != ST_IDLE;
			rx_q.is_cmd <= state_q == ST_CMD;
			rx_q.is_data <= state_q == ST_DATA_IN;
			rx_q.index <= (state_q == ST_ADDR) ? 8'(hdr_cnt_q) : data_idx_q;
			if (byte_done) begin
				rx_q.data <= byte_val;
			end
		end
	end

	// ========================================================================
	// output shifter
	// ========================================================================
	logic [7:0] tx_word;
	logic [2:0] tx_step;

	// a new byte is fetched when the previous one is used up
	assign tx_word = (out_cnt_q == 3'h0) ? tx_data_in : tx_shift_q;
	always_comb begin
		unique case (lanes_q)
			sfb_pkg::SFB_LANES_2: tx_step = 3'h2;
			sfb_pkg::SFB_LANES_4: tx_step = 3'h4;
			default: tx_step = 3'h1;
		endcase
	end
	// handshake: the byte on tx_data_in is taken in this cycle
	assign tx_req_out = sck_fall && state_q == ST_DATA_OUT && out_cnt_q == 3'h0;

	// output advances only on clock fall
	always_ff @(posedge clock_in) begin
		if (!rst_n_in || sel_start) begin
			out_cnt_q <= 3'h0;
			tx_shift_q <= 8'h00;
		end else if (sck_fall && state_q == ST_DATA_OUT) begin
			out_cnt_q <= out_cnt_q + tx_step;
			tx_shift_q <= tx_word << tx_step;
		end
	end

	// ========================================================================
	// lane drivers
	// ========================================================================
	// lanes released whenever select is not held low
	always_ff @(posedge clock_in) begin
		if (!rst_n_in || !sel_active || sel_end || state_q != ST_DATA_OUT) begin
			lane_out_q <= 4'h0;
			lane_oe_q <= 4'h0;
		end else if (sck_fall) begin
			unique case (lanes_q)
				// lane 1 carries the high bit, lane 0 the low one
				sfb_pkg::SFB_LANES_2: begin
					lane_out_q <= {2'b00, tx_word[7:6]};
					lane_oe_q <= 4'h3;
				end
				// protect and hold pins become lanes 2 and 3
				sfb_pkg::SFB_LANES_4: begin
					lane_out_q <= tx_word[7:4];
					lane_oe_q <= 4'hf;
				end
				// one bit per fall on the serial output lane
				default: begin
					lane_out_q <= {2'b00, tx_word[7], 1'b0};
					lane_oe_q <= 4'h2;
				end
			endcase
		end
	end

	// ========================================================================
	// operation hand-off at the close of a frame
	// ========================================================================
	sfb_pkg::sfb_op_kind_t kind;
	logic [1:0] page;
	logic page_ok;
	logic hdr_done;

	assign page = addr_q[sfb_pkg::SFB_SEC_PAGE_LSB +: 2];
	// pages 1 to 3, each refused while its own lock bit is set
	assign page_ok = (page != 2'h0) && !sec_lock_in[2'(page - 2'h1)];
	assign hdr_done = state_q == ST_DATA_IN && hdr_cnt_q == hdr_len_q;

	always_comb begin
		unique case (opcode_q)
			sfb_pkg::SFB_OPC_PROGRAM: kind = sfb_pkg::SFB_OP_PROGRAM;
			sfb_pkg::SFB_OPC_ERASE_4K: kind = sfb_pkg::SFB_OP_ERASE_4K;
			sfb_pkg::SFB_OPC_ERASE_32K: kind = sfb_pkg::SFB_OP_ERASE_32K;
			sfb_pkg::SFB_OPC_ERASE_64K: kind = sfb_pkg::SFB_OP_ERASE_64K;
			sfb_pkg::SFB_OPC_ERASE_CHIP: kind = sfb_pkg::SFB_OP_ERASE_CHIP;
			sfb_pkg::SFB_OPC_SEC_PROGRAM: kind = sfb_pkg::SFB_OP_SEC_PROGRAM;
			sfb_pkg::SFB_OPC_SEC_ERASE: kind = sfb_pkg::SFB_OP_SEC_ERASE;
			default: kind = sfb_pkg::SFB_OP_NONE;
		endcase
	end

	// operation issued only on a byte-aligned select rise
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			op_q <= '0;
		end else begin
			op_q.valid <= 1'b0;
			if (sel_end && bit_cnt_q == 3'h0 && !busy_in) begin
				unique case (kind)
					// program needs at least 1 data byte; the count holds at PAGE_BYTES
					sfb_pkg::SFB_OP_PROGRAM: op_q.valid <= hdr_done && data_cnt_q != 9'h000;
					sfb_pkg::SFB_OP_SEC_PROGRAM:
						op_q.valid <= hdr_done && data_cnt_q != 9'h000 && page_ok;
					sfb_pkg::SFB_OP_SEC_ERASE:
						op_q.valid <= hdr_done && data_cnt_q == 9'h000 && page_ok;
					// whole array erase is the opcode alone
					sfb_pkg::SFB_OP_ERASE_CHIP:
						op_q.valid <= state_q == ST_DATA_IN && data_cnt_q == 9'h000;
					sfb_pkg::SFB_OP_NONE: op_q.valid <= 1'b0;
					default: op_q.valid <= hdr_done && data_cnt_q == 9'h000;
				endcase
				op_q.kind <= kind;
				op_q.addr <= addr_q;
				op_q.count <= data_cnt_q;
				op_q.page <= page;
			end
		end
	end

	// ========================================================================
	// standby indication
	// ========================================================================
	// standby only once deselected and no self-timed cycle runs
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			standby_q <= 1'b1;
		end else begin
			standby_q <= !sel_active && !busy_in && !op_q.valid;
		end
	end

	assign shared_lane_out = lane_out_q;
	assign shared_lane_oe_out = lane_oe_q;
	assign rx_out = rx_q;
	assign op_out = op_q;
	assign selected_out = sel_active;
	assign standby_out = standby_q;
	assign frame_start_out = sel_start;
	assign frame_end_out = sel_end;

endmodule

// ---- bench/sfb_serial_front_checker.sv ----
/* port checker for sfb_serial_front.
 * assumes: bound to every instance; one clock domain, synchronous reset. */
`timescale 1ns/100ps
module sfb_serial_front_checker #(
	parameter int PAGE_BYTES = 256
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic select_n_in,
	input wire logic sck_in,
	input wire logic busy_in,
	input wire logic [2:0] sec_lock_in,
	input wire logic [3:0] shared_lane_out,
	input wire logic [3:0] shared_lane_oe_out,
	input sfb_pkg::sfb_rx_t rx_out,
	input sfb_pkg::sfb_op_t op_out,
	input wire logic selected_out,
	input wire logic standby_out,
	input wire logic frame_start_out,
	input wire logic frame_end_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	// ==========
	// link side: framing, sampling and lanes
	lane_release_a: assert property (!selected_out [*2] |-> shared_lane_oe_out == 4'h0)
		else $error("lanes driven while deselected");
	rx_ignore_a: assert property (!selected_out [*3] |-> !rx_out.valid)
		else $error("byte taken while deselected");
	start_edge_a: assert property ($fell(select_n_in) |-> ##[2:7] frame_start_out)
		else $error("select fall did not open a frame");
	end_edge_a: assert property ($rose(select_n_in) |-> ##[2:7] frame_end_out)
		else $error("select rise did not close the frame");
	rx_on_rise_a: assert property (rx_out.valid |-> sck_in && $past(sck_in, 4))
		else $error("byte taken away from a clock rise");
	fall_only_a: assert property (($changed(shared_lane_out) && |shared_lane_oe_out)
		|-> !sck_in && !$past(sck_in, 3)) else $error("output changed off a clock fall");
	lane_mode_a: assert property (|shared_lane_oe_out |->
		shared_lane_oe_out inside {4'h2, 4'h3, 4'hf} && (selected_out || $past(selected_out)))
		else $error("bad lane enable pattern");
	// ==========
	// operation side: issue, standby, counts
	op_issue_a: assert property (op_out.valid |-> $past(frame_end_out) && !$past(busy_in))
		else $error("operation issued out of turn");
	busy_standby_a: assert property (busy_in [*2] |-> !standby_out)
		else $error("standby during a busy cycle");
	idle_standby_a: assert property ((!selected_out && !busy_in && !op_out.valid) [*3]
		|-> standby_out) else $error("idle device not in standby");
	prog_count_a: assert property (op_out.valid && op_out.kind == sfb_pkg::SFB_OP_PROGRAM
		|-> op_out.count inside {[1:PAGE_BYTES]}) else $error("program count out of range");
	sec_lock_a: assert property (op_out.valid && op_out.kind == sfb_pkg::SFB_OP_SEC_PROGRAM
		|-> op_out.page != 2'h0 && !sec_lock_in[op_out.page - 2'h1])
		else $error("locked security page written");
endmodule

bind sfb_serial_front sfb_serial_front_checker #(.PAGE_BYTES(PAGE_BYTES)) u_sfb_serial_front_checker (
	.clock_in, .rst_n_in, .select_n_in, .sck_in, .busy_in, .sec_lock_in, .shared_lane_out,
	.shared_lane_oe_out, .rx_out, .op_out, .selected_out, .standby_out, .frame_start_out,
	.frame_end_out);

// ---- bench/sfb_host_model.sv ----
/* behavioural host controller driving select, serial clock and lane 0.
 * assumes: called from the bench; half link period is 20 clocks of 4 ns. */
`timescale 1ns/100ps
module sfb_host_model (
	input wire logic clock_in,
	input wire logic [3:0] lanes_in,
	output logic select_n_out,
	output logic sck_out,
	output logic mosi_out
);
	localparam int HALF = 20; // 80 ns, half of the 160 ns link period
	logic idle_q = 1'b0;
	// pins idle: deselected, clock low
	initial begin
		select_n_out = 1'b1;
		sck_out = 1'b0;
		mosi_out = 1'b0;
	end
	task automatic wait_half();
		repeat (HALF) @(posedge clock_in);
	endtask
	task automatic open_frame(input logic mode3);
		idle_q = mode3;
		sck_out <= mode3;
		wait_half();
		select_n_out <= 1'b0;
		wait_half();
	endtask
	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			sck_out <= 1'b0;
			mosi_out <= b[i];
			wait_half();
			sck_out <= 1'b1;
			wait_half();
		end
	endtask
	// sample on the rise, half a period after the device's fall
	task automatic recv_byte(input int w, output logic [7:0] b);
		b = 8'h00;
		for (int i = 0; i < 8 / w; i++) begin
			sck_out <= 1'b0;
			wait_half();
			sck_out <= 1'b1;
			if (w == 1) b = {b[6:0], lanes_in[1]};
			else if (w == 2) b = {b[5:0], lanes_in[1:0]};
			else b = {b[3:0], lanes_in};
			wait_half();
		end
	endtask
	task automatic close_frame();
		sck_out <= idle_q;
		wait_half();
		select_n_out <= 1'b1;
		wait_half();
	endtask
	// deliberate link activity with the device deselected
	task automatic noise();
		for (int i = 0; i < 16; i++) begin
			sck_out <= ~sck_out;
			mosi_out <= ~mosi_out;
			wait_half();
		end
	endtask
endmodule

// ---- bench/serial_flash_bus_interface_test.sv ----
/* self-checking bench for sfb_serial_front with a host model.
 * assumes: checker bound by its own file; short page for cheap counts. */
`timescale 1ns/100ps
module serial_flash_bus_interface_test;
	localparam int PB = 4; // saturation shows after five bytes, not 257
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic busy_in = 1'b0;
	logic [2:0] sec_lock_in = 3'h0;
	logic [7:0] tx_data_in = 8'h5a;
	logic select_n_in, sck_in, mosi, tx_req_out, selected_out, standby_out;
	logic frame_start_out, frame_end_out;
	logic [3:0] shared_lane_in, shared_lane_out, shared_lane_oe_out;
	sfb_pkg::sfb_rx_t rx_out;
	sfb_pkg::sfb_op_t op_out, e;
	sfb_pkg::sfb_op_t exp_q[$];
	logic [7:0] tx_q[$];
	logic [31:0] seed = 32'h03e7dff4;
	logic req_seen = 1'b0;
	int num_errors = 0;
	int compares = 0;

	always #2 clock_in = ~clock_in;
	// released lanes 3 to 1 read high: 3 and 2 pulled up, 1 inverted from its last 0; lane 0 follows the host
	assign shared_lane_in = (shared_lane_out & shared_lane_oe_out)
		| ({2'b11, ~shared_lane_out[1], mosi} & ~shared_lane_oe_out);

	sfb_serial_front #(.PAGE_BYTES(PB)) u_sfb_serial_front (.clock_in, .rst_n_in,
		.select_n_in, .sck_in, .shared_lane_in, .shared_lane_out, .shared_lane_oe_out,
		.busy_in, .sec_lock_in, .tx_data_in, .tx_req_out, .rx_out, .op_out, .selected_out,
		.standby_out, .frame_start_out, .frame_end_out);
	sfb_host_model u_sfb_host_model (.clock_in, .lanes_in(shared_lane_in),
		.select_n_out(select_n_in), .sck_out(sck_in), .mosi_out(mosi));

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic check(input string n, input logic [31:0] ex, input logic [31:0] got);
		compares++;
		if (got !== ex) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", n, ex, got);
		end
	endtask
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// read bytes: note each fetched byte, offer a fresh one after the fetch edge
	always @(negedge clock_in) begin
		req_seen = (tx_req_out === 1'b1);
		if (req_seen) tx_q.push_back(tx_data_in);
	end
	always @(posedge clock_in) if (req_seen) tx_data_in <= 8'(rnd());
	// op watcher: an op with no note meets an empty note and fails on kind
	always @(negedge clock_in) if (op_out.valid === 1'b1) begin
		e = exp_q.size() ? exp_q.pop_front() : '0;
		check("op kind", e.kind, op_out.kind);
		check("op addr", e.addr, op_out.addr);
		check("op count", e.count, op_out.count);
	end

	task automatic hdr(input logic [7:0] opc, input int nb, input logic [23:0] a, input logic m3);
		u_sfb_host_model.open_frame(m3);
		u_sfb_host_model.send_byte(opc);
		for (int i = 0; i < nb; i++) u_sfb_host_model.send_byte(a[23 - 8 * i -: 8]);
	endtask
	// write-side frame; address bit 0 picks the clock mode
	task automatic wr(input logic [7:0] opc, input sfb_pkg::sfb_op_kind_t k,
		input logic [23:0] a, input int nd, input int cnt);
		hdr(opc, (opc == sfb_pkg::SFB_OPC_ERASE_CHIP) ? 0 : 3, a, a[0]);
		for (int i = 0; i < nd; i++) u_sfb_host_model.send_byte(8'(rnd()));
		if (k != sfb_pkg::SFB_OP_NONE) exp_q.push_back('{1'b1, k, a, 9'(cnt), 2'h0});
		u_sfb_host_model.close_frame();
		repeat (8) @(posedge clock_in);
	endtask
	task automatic rd(input logic [7:0] opc, input int w, input logic m3);
		logic [7:0] b;
		tx_q.delete();
		hdr(opc, 3, 24'(rnd()), m3);
		if (opc != sfb_pkg::SFB_OPC_READ) u_sfb_host_model.send_byte(8'(rnd()));
		for (int i = 0; i < 2; i++) begin
			u_sfb_host_model.recv_byte(w, b);
			check("read fetched", 1, tx_q.size() > 0);
			if (tx_q.size() > 0) check("read byte", tx_q.pop_front(), b);
		end
		u_sfb_host_model.close_frame();
		$display("done read %h", opc);
	endtask

	// hang guard
	initial begin
		repeat (100000) @(posedge clock_in);
		check("run length", 0, 1);
		end_of_test();
	end
	// main sequence
	initial begin
		repeat (12) @(posedge clock_in);
		rst_n_in <= 1'b1;
		repeat (8) @(posedge clock_in);
		wr(sfb_pkg::SFB_OPC_ERASE_4K, sfb_pkg::SFB_OP_ERASE_4K, 24'(rnd()), 0, 0);
		wr(sfb_pkg::SFB_OPC_ERASE_32K, sfb_pkg::SFB_OP_ERASE_32K, 24'(rnd()), 0, 0);
		wr(sfb_pkg::SFB_OPC_ERASE_64K, sfb_pkg::SFB_OP_ERASE_64K, 24'(rnd()), 0, 0);
		wr(sfb_pkg::SFB_OPC_ERASE_CHIP, sfb_pkg::SFB_OP_ERASE_CHIP, 24'h0, 0, 0);
		$display("done erase");
		wr(sfb_pkg::SFB_OPC_PROGRAM, sfb_pkg::SFB_OP_PROGRAM, 24'(rnd()), 1, 1);
		wr(sfb_pkg::SFB_OPC_PROGRAM, sfb_pkg::SFB_OP_PROGRAM, 24'(rnd()), PB + 1, PB);
		wr(sfb_pkg::SFB_OPC_PROGRAM, sfb_pkg::SFB_OP_NONE, 24'(rnd()), 0, 0);
		$display("done program");
		busy_in <= 1'b1;
		wr(sfb_pkg::SFB_OPC_ERASE_4K, sfb_pkg::SFB_OP_NONE, 24'(rnd()), 0, 0);
		@(negedge clock_in);
		check("standby while busy", 0, standby_out);
		@(posedge clock_in);
		busy_in <= 1'b0;
		repeat (4) @(posedge clock_in);
		@(negedge clock_in);
		check("standby when idle", 1, standby_out);
		$display("done busy");
		for (int p = 1; p < 4; p++) begin
			sec_lock_in <= 3'h7 ^ (3'h1 << (p - 1));
			wr(sfb_pkg::SFB_OPC_SEC_PROGRAM, sfb_pkg::SFB_OP_SEC_PROGRAM, {10'h0, 2'(p), 12'h0}, 1, 1);
			sec_lock_in <= 3'h1 << (p - 1);
			wr(sfb_pkg::SFB_OPC_SEC_PROGRAM, sfb_pkg::SFB_OP_NONE, {10'h0, 2'(p), 12'h0}, 1, 0);
		end
		$display("done security");
		rd(sfb_pkg::SFB_OPC_READ, 1, 1'b0);
		rd(sfb_pkg::SFB_OPC_FAST_READ, 1, 1'b1);
		rd(sfb_pkg::SFB_OPC_DUAL_READ, 2, 1'b0);
		rd(sfb_pkg::SFB_OPC_QUAD_READ, 4, 1'b1);
		u_sfb_host_model.noise();
		check("lanes deselected", 0, shared_lane_oe_out);
		wr(sfb_pkg::SFB_OPC_ERASE_4K, sfb_pkg::SFB_OP_ERASE_4K, 24'h123456, 0, 0);
		$display("done deselect");
		check("ops pending", 0, exp_q.size());
		end_of_test();
	end
endmodule
